// [wdh_pkg.sv]
package wdh_pkg;
    // ==========================================================
    // register map
    localparam logic [7:0] WDH_CTRL_OFS = 8'h00;
    localparam logic [7:0] WDH_STAT_OFS = 8'h04;
    localparam logic [7:0] WDH_CTRL_RST = 8'h7F;
    localparam int WDH_ACT_BIT = 7;
    localparam int WDH_TOP_BIT = 6;
    // ==========================================================
    // timing
    localparam int WDH_TICK_DIV = 16384;
    localparam int WDH_CLK_MHZ = 40;
    localparam int WDH_PULSE_NS = 500;
    localparam int WDH_PULSE_CYC = (WDH_PULSE_NS * WDH_CLK_MHZ) / 1000;
    localparam int WDH_WAKE_SHORT = 256;
    localparam int WDH_WAKE_LONG = 4096;
    // ==========================================================
    // states
    typedef enum logic [1:0] {
        WDH_RUN,
        WDH_HALT_STOP,
        WDH_WAKE_WAIT
    } wdh_state_t;
endpackage

// [wdh_bus_if.sv]
`timescale 1ns/1ps
interface wdh_bus_if;
    logic wr_en;
    logic [7:0] wdata;
    logic [7:0] ctrl;
    modport slave (input ctrl, output wr_en, output wdata);
    modport core (output ctrl, input wr_en, input wdata);
endinterface

// [wdh_apb.sv]
`timescale 1ns/1ps
module wdh_apb
    import wdh_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [7:0] status,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    wdh_bus_if.slave bus
);
    // ==========================================================
    // apb slave, zero wait states
    logic [31:0] rdata_reg, rdata_next;
    logic hit;
    always_comb begin
        hit = (paddr == WDH_CTRL_OFS) || (paddr == WDH_STAT_OFS);
        pready = 1'b1;
        pslverr = psel && penable && !hit;
        bus.wr_en = psel && penable && pwrite && (paddr == WDH_CTRL_OFS);
        bus.wdata = pwdata[7:0];
        rdata_next = rdata_reg;
        if (psel && !penable && !pwrite) begin
            if (paddr == WDH_CTRL_OFS)
                rdata_next = {24'h000000, bus.ctrl};
            else if (paddr == WDH_STAT_OFS)
                rdata_next = {24'h000000, status};
            else
                rdata_next = 32'h00000000;
        end
    end
    always_ff @(posedge clk) begin
        if (sys_rst)
            rdata_reg <= 32'h00000000;
        else
            rdata_reg <= rdata_next;
    end
    assign prdata = rdata_reg;
endmodule

// [wdh_top.sv]
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
// Function
// RQ1 - counter decrements every 16384 divided-oscillator cycles, armed or not
// RQ2 - armed watchdog resets when counter rolls 40h to 3Fh
// RQ3 - activation bit set by write only, cleared only by reset
// RQ4 - no watchdog reset while activation bit is zero; a halt with the halt-reset option set still resets here even then
// RQ5 - control register resets to 7Fh
// RQ6 - hardware watchdog option forces active, activation bit ignored
// RQ7 - plain halt: no reset, one more decrement, then stop and block
// RQ8 - interrupt ends halt: resume after 256 or 4096 cpu clocks
// RQ9 - reset ends halt: watchdog back to disabled reset state
// RQ10 - halt with halt-reset option set and rtc disabled gives reset
// RQ11 - rtc enable set: active-halt, counter frozen, no reset
// RQ12 - interrupt ends active-halt: counting resumes at once
// RQ13 - reset ends active-halt: resume after 256 or 4096 cpu clocks
// RQ14 - software should refresh the counter before halting
// RQ15 - write activation one, top bit zero: immediate software reset
// RQ16 - watchdog reset drives reset line low for about 500ns
// RQ17 - control write loads counter at once, prescaler phase kept
module wdh_top
    import wdh_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic pslverr,
    output logic [31:0] prdata,
    input wire logic osc_div_tick,
    input wire logic hw_watchdog_option,
    input wire logic halt_reset_option,
    input wire logic rtc_interrupt_enable,
    input wire logic halt_enter,
    input wire logic wake_irq,
    input wire logic wake_long_delay,
    input wire logic reset_caused_wake,
    output logic halt_granted,
    output logic wdg_reset_n
);
    // ==========================================================
    // bus slave
    wdh_bus_if bus ();
    logic [7:0] status;
    wdh_apb u_apb (
        .clk(clk),
        .sys_rst(sys_rst),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .status(status),
        .pready(pready),
        .pslverr(pslverr),
        .prdata(prdata),
        .bus(bus)
    );
    // ==========================================================
    // state
    logic act_reg, act_next;
    logic [6:0] cnt_reg, cnt_next;
    logic [13:0] pre_reg, pre_next;
    wdh_state_t st_reg, st_next;
    logic last_dec_reg, last_dec_next;
    logic [12:0] wake_reg, wake_next;
    logic [4:0] pulse_reg, pulse_next;
    logic halt_ok_reg, halt_ok_next;
    logic rie_reg, rie_next;
    logic rst_wake_reg, rst_wake_next;
    logic armed, tick, fire, counting;

    function automatic logic [12:0] wake_len(input logic long_sel);
        wake_len = long_sel ? 13'(WDH_WAKE_LONG - 1)
                            : 13'(WDH_WAKE_SHORT - 1);
    endfunction

    always_comb begin
        armed = act_reg || hw_watchdog_option; // [RQ6] [RQ4]
        // prescaler free-runs; a write never touches it [RQ17]
        pre_next = pre_reg + 14'h0001;
        tick = osc_div_tick && (pre_reg == 14'(WDH_TICK_DIV - 1)); // [RQ1]
        if (!osc_div_tick)
            pre_next = pre_reg;
        st_next = st_reg;
        last_dec_next = 1'b0;
        wake_next = wake_reg;
        halt_ok_next = 1'b0;
        counting = (st_reg == WDH_RUN) || last_dec_reg;
        act_next = act_reg;
        cnt_next = cnt_reg;
        fire = 1'b0;
        if (counting && tick) begin
            cnt_next = cnt_reg - 7'h01; // [RQ1]
            // roll 40h to 3Fh only resets while armed [RQ2] [RQ4]
            if (cnt_reg == 7'h40 && armed && st_reg == WDH_RUN)
                fire = 1'b1;
        end
        if (bus.wr_en) begin
            cnt_next = bus.wdata[6:0]; // [RQ17]
            if (bus.wdata[WDH_ACT_BIT])
                act_next = 1'b1; // zero write never disarms [RQ3]
            if (bus.wdata[WDH_ACT_BIT] && !bus.wdata[WDH_TOP_BIT])
                fire = 1'b1; // [RQ15]
        end
        case (st_reg)
            WDH_RUN: begin
                if (halt_enter) begin
                    if (rtc_interrupt_enable) begin
                        st_next = WDH_HALT_STOP; // frozen [RQ11]
                        halt_ok_next = 1'b1;
                    end else if (halt_reset_option) begin
                        fire = 1'b1; // [RQ10]
                    end else begin
                        st_next = WDH_HALT_STOP; // [RQ7]
                        last_dec_next = 1'b1;
                        halt_ok_next = 1'b1;
                    end
                end
            end
            WDH_HALT_STOP: begin
                halt_ok_next = 1'b1;
                // one pending decrement survives into halt [RQ7]
                last_dec_next = last_dec_reg && !tick;
                if (wake_irq) begin
                    halt_ok_next = 1'b0;
                    last_dec_next = 1'b0;
                    if (rie_reg) begin
                        st_next = WDH_RUN; // [RQ12]
                    end else begin
                        st_next = WDH_WAKE_WAIT; // [RQ8]
                        wake_next = wake_len(wake_long_delay);
                    end
                end
            end
            WDH_WAKE_WAIT: begin
                if (wake_reg == 13'h0000)
                    st_next = WDH_RUN;
                else
                    wake_next = wake_reg - 13'h0001;
            end
            default: st_next = WDH_RUN;
        endcase
        // a reset that ended active-halt holds counting off for the
        // wake delay; reset alone cannot tell which halt it ended [RQ13]
        if (rst_wake_reg && reset_caused_wake) begin
            st_next = WDH_WAKE_WAIT;
            wake_next = wake_len(wake_long_delay);
        end
        pulse_next = pulse_reg;
        if (fire)
            pulse_next = 5'(WDH_PULSE_CYC); // [RQ16]
        else if (pulse_reg != 5'h00)
            pulse_next = pulse_reg - 5'h01;
    end

    // halt kind is latched so a later rtc enable change cannot alter it
    always_comb begin
        rie_next = rie_reg;
        if (st_reg == WDH_RUN && halt_enter)
            rie_next = rtc_interrupt_enable;
    end

    // ==========================================================
    // registers
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            act_reg <= 1'b0; // [RQ9]
            cnt_reg <= WDH_CTRL_RST[6:0]; // [RQ5]
            pre_reg <= 14'h0000;
            last_dec_reg <= 1'b0;
            halt_ok_reg <= 1'b0;
            rie_reg <= 1'b0;
            wake_reg <= 13'h0000;
            st_reg <= WDH_RUN;
            pulse_reg <= 5'h00;
        end else begin
            act_reg <= act_next;
            cnt_reg <= cnt_next;
            pre_reg <= pre_next;
            last_dec_reg <= last_dec_next;
            halt_ok_reg <= halt_ok_next;
            rie_reg <= rie_next;
            wake_reg <= wake_next;
            st_reg <= st_next;
            pulse_reg <= pulse_next;
        end
    end

    // high during reset and for the first cycle after it
    always_comb begin
        rst_wake_next = 1'b0;
    end
    always_ff @(posedge clk) begin
        if (sys_rst)
            rst_wake_reg <= 1'b1;
        else
            rst_wake_reg <= rst_wake_next;
    end

    assign bus.ctrl = {act_reg, cnt_reg};
    assign status = {5'h00, st_reg == WDH_WAKE_WAIT,
                     st_reg == WDH_HALT_STOP, armed};
    assign halt_granted = halt_ok_reg;
    assign wdg_reset_n = (pulse_reg == 5'h00); // [RQ16]
endmodule

// [wdh_checker.sv]
`timescale 1ns/1ps
// ==========================================================
// watchdog port checker
module wdh_checker
    import wdh_pkg::*;
(
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic halt_reset_option,
    input wire logic rtc_interrupt_enable,
    input wire logic halt_enter,
    input wire logic wake_irq,
    input wire logic halt_granted,
    input wire logic wdg_reset_n
);
    // pulse length is too long for a repetition, so count it
    int low_reg;
    int low_next;
    logic ctrl_wr;
    always_comb begin
        low_next = wdg_reset_n ? 0 : low_reg + 1;
    end
    always_ff @(posedge clk) begin
        low_reg <= sys_rst ? 0 : low_next;
    end
    assign ctrl_wr = psel && penable && pwrite && paddr == WDH_CTRL_OFS;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    a_ready_high: assert property (pready) else $error("pready low");
    a_err_unmapped: assert property (psel && penable
        && paddr != WDH_CTRL_OFS && paddr != WDH_STAT_OFS |-> pslverr)
        else $error("unmapped access without slverr");
    a_pulse_len: assert property (
        $rose(wdg_reset_n) |-> low_reg == WDH_PULSE_CYC)
        else $error("reset pulse length wrong");
    a_soft_reset: assert property (
        ctrl_wr && pwdata[7:6] == 2'h2 |-> ##[1:2] !wdg_reset_n)
        else $error("software reset missing");
    a_halt_grant: assert property (
        halt_enter && !halt_granted && wdg_reset_n
        && (rtc_interrupt_enable || !halt_reset_option)
        |-> ##[1:2] halt_granted) else $error("halt not granted");
    a_halt_quiet: assert property (
        halt_granted && wdg_reset_n |=> wdg_reset_n)
        else $error("reset while halted");
    a_wake_exit: assert property (
        halt_granted && wake_irq |-> ##[1:2] !halt_granted)
        else $error("halt not left on wake");
    a_reset_state: assert property (
        $fell(sys_rst) |-> wdg_reset_n && !halt_granted)
        else $error("state after reset wrong");
endmodule

bind wdh_top wdh_checker u_chk (
    .clk(clk),
    .sys_rst(sys_rst),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .halt_reset_option(halt_reset_option),
    .rtc_interrupt_enable(rtc_interrupt_enable),
    .halt_enter(halt_enter),
    .wake_irq(wake_irq),
    .halt_granted(halt_granted),
    .wdg_reset_n(wdg_reset_n)
);

// [watchdog_halt_behaviour_tb_top.sv]
`timescale 1ns/1ps
module watchdog_halt_behaviour_tb_top;
    import wdh_pkg::*;
    typedef struct {
        logic [7:0] a;
        logic [31:0] d;
        logic [31:0] x;
        logic err;
    } wdh_row_t;
    logic clk = 1'h0, sys_rst = 1'h1, psel = 1'h0, penable = 1'h0;
    logic pwrite = 1'h0, tick = 1'h0, hw_opt = 1'h0, halt_opt = 1'h0;
    logic rtc_en = 1'h0, halt_enter = 1'h0, wake_irq = 1'h0, e, saw = 1'h0;
    logic long_sel = 1'h0, rst_wake = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, r, prdata;
    logic pready, pslverr, halt_granted, wdg_reset_n;
    int bad_count = 0, total_checks = 0, len;
    wdh_row_t rows[3] = '{'{8'h00, 32'h41, 32'h41, 1'h0},
        '{8'h00, 32'h7F, 32'h7F, 1'h0}, '{8'h08, 32'hFF, 32'h0, 1'h1}};
    wdh_top i_dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .pslverr(pslverr), .prdata(prdata),
        .osc_div_tick(tick), .hw_watchdog_option(hw_opt),
        .halt_reset_option(halt_opt), .rtc_interrupt_enable(rtc_en),
        .halt_enter(halt_enter), .wake_irq(wake_irq),
        .wake_long_delay(long_sel), .reset_caused_wake(rst_wake),
        .halt_granted(halt_granted), .wdg_reset_n(wdg_reset_n));
    initial forever #12.5 clk = ~clk;
    always @(posedge clk) begin
        if (wdg_reset_n === 1'h0)
            saw <= 1'h1;
    end
    // ==========================================================
    // tasks
    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] s,
                       input logic [31:0] x);
        total_checks++;
        if (s !== x) begin
            bad_count++;
            $display("[FAIL] %s expected %h seen %h", nm, x, s);
        end
    endtask
    // idle edge at the end keeps back-to-back calls from double driving
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        // no answer time assumed; only the watchdog ends this wait
        do begin
            @(posedge clk);
        end while (pready !== 1'h1);
        r = prdata;
        e = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [31:0] d);
        apb(1'h1, WDH_CTRL_OFS, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x,
                      input string nm);
        apb(1'h0, a, 32'h0);
        chk(nm, r, x);
    endtask
    task automatic rst();
        sys_rst <= 1'h1;
        repeat (8) @(posedge clk);
        sys_rst <= 1'h0;
        @(posedge clk);
        saw <= 1'h0;
    endtask
    task automatic pulse(input int lim);
        int n;
        n = 0;
        len = 0;
        while (wdg_reset_n !== 1'h0 && n < lim) begin
            @(posedge clk);
            n++;
        end
        while (wdg_reset_n === 1'h0 && len < 99) begin
            @(posedge clk);
            len++;
        end
    endtask
    task automatic strobe(input logic w);
        if (w)
            wake_irq <= 1'h1;
        else
            halt_enter <= 1'h1;
        @(posedge clk);
        wake_irq <= 1'h0;
        halt_enter <= 1'h0;
        @(posedge clk);
    endtask
    task automatic ticks(input int n);
        tick <= 1'h1;
        repeat (n) @(posedge clk);
        tick <= 1'h0;
    endtask
    initial begin
        repeat (99000) @(posedge clk);
        bad_count++;
        conclude();
    end
    // ==========================================================
    // sequence
    initial begin
        rst();
        rd(WDH_CTRL_OFS, 32'h7F, "ctrl reset");
        foreach (rows[i]) begin
            apb(1'h1, rows[i].a, rows[i].d);
            chk("pslverr", e, rows[i].err);
            rd(rows[i].a, rows[i].x, "readback");
        end
        wr(32'h40);
        ticks(16390);
        rd(WDH_CTRL_OFS, 32'h3F, "free run");
        chk("unarmed", saw, 32'h0);
        wr(32'hFF);
        wr(32'h7F);
        rd(WDH_CTRL_OFS, 32'hFF, "arm kept");
        rd(WDH_STAT_OFS, 32'h1, "status armed");
        wr(32'hC0);
        tick <= 1'h1;
        pulse(16400);
        tick <= 1'h0;
        chk("expiry pulse", len, WDH_PULSE_CYC);
        rst();
        rd(WDH_CTRL_OFS, 32'h7F, "disarmed");
        wr(32'h80);
        pulse(4);
        chk("soft reset", len, WDH_PULSE_CYC);
        rst();
        hw_opt <= 1'h1;
        wr(32'h40);
        tick <= 1'h1;
        pulse(16400);
        chk("hw option", len, WDH_PULSE_CYC);
        tick <= 1'h0;
        rst();
        hw_opt <= 1'h0;
        halt_opt <= 1'h1;
        wr(32'hFF);
        strobe(1'h0);
        pulse(4);
        chk("halt reset", len, WDH_PULSE_CYC);
        chk("no halt", halt_granted, 32'h0);
        rst();
        halt_opt <= 1'h0;
        // software refreshes the counter just before halting
        wr(32'hC1);
        strobe(1'h0);
        ticks(16500);
        chk("halted", halt_granted, 32'h1);
        rd(WDH_CTRL_OFS, 32'hC0, "one decrement");
        chk("blocked", saw, 32'h0);
        strobe(1'h1);
        rd(WDH_STAT_OFS, 32'h5, "wake delay");
        repeat (260) @(posedge clk);
        rd(WDH_STAT_OFS, 32'h1, "delay over");
        rst();
        rtc_en <= 1'h1;
        // refresh before active-halt as well
        wr(32'hC1);
        strobe(1'h0);
        ticks(16500);
        rd(WDH_CTRL_OFS, 32'hC1, "frozen");
        strobe(1'h1);
        rd(WDH_STAT_OFS, 32'h1, "no delay");
        // active-halt again, this time ended by a reset, long delay
        strobe(1'h0);
        rst_wake <= 1'h1;
        long_sel <= 1'h1;
        rst();
        rst_wake <= 1'h0;
        rd(WDH_STAT_OFS, 32'h4, "reset wake delay");
        repeat (4100) @(posedge clk);
        rd(WDH_STAT_OFS, 32'h0, "reset wake over");
        conclude();
    end
endmodule
